//--- rtl/dbc_defines.svh
`ifndef DBC_DEFINES_SVH
`define DBC_DEFINES_SVH

// register byte offsets
`define DBC_OFS_CTRL 8'h00
`define DBC_OFS_STATE 8'h04
`define DBC_OFS_COMMS 8'h08
`define DBC_OFS_ISTAT 8'h0c
`define DBC_OFS_IMASK 8'h10
`define DBC_OFS_WP_BASE 8'h20
`define DBC_WP_STRIDE_LOG2 4
`define DBC_WP_ADDR 2'h0
`define DBC_WP_AMASK 2'h1
`define DBC_WP_DATA 2'h2
`define DBC_WP_CTRL 2'h3

// control register fields
`define DBC_CTRL_RESTART 0
`define DBC_CTRL_DBGREQ 1

// interrupt status fields
`define DBC_IRQ_ENTRY 0
`define DBC_IRQ_TXEMPTY 1
`define DBC_IRQ_RNG0 2
`define DBC_IRQ_RNG1 3
`define DBC_IRQ_W 4

// reset values
`define DBC_RST_WORD 32'h0000_0000
`define DBC_RST_WPCTRL 8'h00
`define DBC_RST_IMASK 4'h0

// test access instruction that selects the id code chain
`define DBC_IR_IDCODE 4'he

// bus responses
`define DBC_RESP_OKAY 2'h0
`define DBC_RESP_SLVERR 2'h2

`endif

//--- rtl/dbc_pkg.sv
package dbc_pkg;

  // debug mode of the core
  typedef enum logic {
    MODE_RUN = 1'b0,
    MODE_DEBUG = 1'b1
  } dbc_mode_t;

  // watchpoint unit configuration word
  typedef struct packed {
    logic [1:0] ext_val;
    logic [1:0] ext_care;
    logic rw_val;
    logic rw_care;
    logic data_care;
    logic enable;
  } dbc_wp_ctrl_t;

  // core pipeline and data bus view
  typedef struct packed {
    logic fetch_complete;
    logic pipe_advance;
    logic exec_valid;
    logic exec_cond_pass;
    logic exec_discard;
    logic data_req_end;
    logic data_write;
    logic [31:0] addr;
    logic [31:0] data;
  } dbc_core_t;

  // test access port strobes
  typedef struct packed {
    logic [3:0] ir;
    logic capture_dr;
    logic shift_dr;
    logic comms_read;
  } dbc_tap_t;

endpackage

//--- rtl/dbc_watch_unit.sv
`timescale 1ns/1ps
module dbc_watch_unit (
  input wire dbc_pkg::dbc_core_t core,
  input wire logic [1:0] ext_cond,
  input wire logic [31:0] addr_val,
  input wire logic [31:0] addr_mask,
  input wire logic [31:0] data_val,
  input wire dbc_pkg::dbc_wp_ctrl_t ctrl,
  output logic range_hit,
  output logic armed_hit
);
  logic addr_ok;
  logic data_ok;
  logic rw_ok;
  logic ext_ok;

  // compare buses; mask bits set mean ignore
  always_comb begin
    addr_ok = ((core.addr ^ addr_val) & ~addr_mask) == 32'h0000_0000;
    data_ok = !ctrl.data_care || (core.data == data_val);
    rw_ok = !ctrl.rw_care || (core.data_write == ctrl.rw_val);
    // RL6: external condition qualify
    ext_ok = ((ext_cond ^ ctrl.ext_val) & ctrl.ext_care) == 2'h0;
    // RL8: match ignores enable
    range_hit = core.data_req_end && addr_ok && data_ok && rw_ok && ext_ok;
    armed_hit = range_hit && ctrl.enable;
  end
endmodule // dbc_watch_unit

//--- rtl/dbc_id_shift.sv
`timescale 1ns/1ps
`include "dbc_defines.svh"
module dbc_id_shift (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dbc_pkg::dbc_tap_t tap,
  input wire logic [31:0] scan_id_value,
  output logic test_data_out
);
  logic [31:0] sreg;
  logic [31:0] next_sreg;
  logic tdo;
  logic next_tdo;

  // capture id code, then shift lsb first
  always_comb begin
    next_sreg = sreg;
    next_tdo = tdo;
    // RL9: load id code
    if (tap.capture_dr && tap.ir == `DBC_IR_IDCODE) begin
      next_sreg = scan_id_value;
    end else if (tap.shift_dr) begin
      next_tdo = sreg[0];
      next_sreg = {1'b0, sreg[31:1]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sreg <= `DBC_RST_WORD;
      tdo <= 1'b0;
    end else begin
      sreg <= next_sreg;
      tdo <= next_tdo;
    end
  end

  assign test_data_out = tdo;

  a_id_first_bit: assert property (@(posedge aclk) disable iff (!aresetn)
    (tap.capture_dr && tap.ir == `DBC_IR_IDCODE) ##1 tap.shift_dr
    |=> test_data_out == $past(scan_id_value[0], 2)) // RL9
    else $error("first id code bit wrong");
endmodule // dbc_id_shift

//--- rtl/dbc_debug_ctrl.sv
// How it works
// RL1: comms empty output low while transmit word not yet drained.
// RL2: acknowledge output high exactly while the core sits in debug state.
// RL3: debug entry only while enable input high; otherwise debug disabled.
// RL4: internal request is external request ORed with control bit one.
// RL5: external request moves the core into debug state.
// RL6: two external condition bits qualify each watchpoint unit match.
// RL7: executed pulse only for execute-stage instructions that really run.
// RL8: range outputs follow unit matches regardless of enable bit.
// RL9: id code value shifts out on test data when id selected.
// RL10: breakpoint input tags fetch; debug entry when tag reaches execute.
// RL11: watchpoint input at data request end forces debug entry.
// RL12: debugger holds external request until acknowledge is seen.
`timescale 1ns/1ps
`include "dbc_defines.svh"
module dbc_debug_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic debug_features_enable,
  input wire logic external_debug_request,
  input wire logic [1:0] external_match_condition,
  input wire logic instruction_breakpoint_in,
  input wire logic data_watchpoint_in,
  input wire logic [31:0] scan_id_value,
  input wire dbc_pkg::dbc_core_t core,
  input wire dbc_pkg::dbc_tap_t tap,
  output logic comms_tx_empty,
  output logic [31:0] comms_tx_data,
  output logic debug_state_ack,
  output logic internal_debug_request,
  output logic instruction_executed,
  output logic [1:0] watchpoint_range_match,
  output logic test_data_out,
  output logic irq
);
  // byte-lane merge used by the watchpoint address, mask and data registers and the comms word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = wd[8*b +: 8];
    end
    return res;
  endfunction

  // true when an address falls in the watchpoint window
  function automatic logic is_wp(input logic [7:0] a);
    return a[7:5] == 3'(`DBC_OFS_WP_BASE >> 5);
  endfunction

  // bus state
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  // control state
  dbc_pkg::dbc_mode_t mode, next_mode;
  logic ctrl_req, next_ctrl_req;
  logic tx_full, next_tx_full;
  logic [31:0] tx_word, next_tx_word;
  logic dec_tag, next_dec_tag, exe_tag, next_exe_tag;
  logic [3:0] istat, next_istat, imask, next_imask;
  logic irq_q, next_irq_q, iexec, next_iexec, intreq, next_intreq;
  logic [1:0] rng, next_rng;
  logic [31:0] wp_addr [2], next_wp_addr [2];
  logic [31:0] wp_amask [2], next_wp_amask [2];
  logic [31:0] wp_data [2], next_wp_data [2];
  dbc_pkg::dbc_wp_ctrl_t wp_ctrl [2], next_wp_ctrl [2];
  logic [1:0] range_hit, armed_hit;
  logic wr_go, rd_go, enter, restart;
  logic [31:0] rd_word;
  logic rd_ok;

  // two watchpoint comparators
  for (genvar i = 0; i < 2; i++) begin : g_wp
    dbc_watch_unit u_wp (
      .core(core),
      .ext_cond(external_match_condition),
      .addr_val(wp_addr[i]),
      .addr_mask(wp_amask[i]),
      .data_val(wp_data[i]),
      .ctrl(wp_ctrl[i]),
      .range_hit(range_hit[i]),
      .armed_hit(armed_hit[i])
    );
  end

  dbc_id_shift u_id (
    .aclk(aclk),
    .aresetn(aresetn),
    .tap(tap),
    .scan_id_value(scan_id_value),
    .test_data_out(test_data_out)
  );

  // read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (is_wp(s_axi_araddr) && s_axi_araddr[1:0] == 2'h0) begin
      case (s_axi_araddr[3:2])
        `DBC_WP_ADDR: rd_word = wp_addr[s_axi_araddr[4]];
        `DBC_WP_AMASK: rd_word = wp_amask[s_axi_araddr[4]];
        `DBC_WP_DATA: rd_word = wp_data[s_axi_araddr[4]];
        default: rd_word = {24'h0, wp_ctrl[s_axi_araddr[4]]};
      endcase
    end else begin
      case (s_axi_araddr)
        `DBC_OFS_CTRL: rd_word = {30'h0, ctrl_req, 1'b0};
        `DBC_OFS_STATE: rd_word = {26'h0, rng, intreq,
                                   debug_features_enable, !tx_full,
                                   mode == dbc_pkg::MODE_DEBUG};
        `DBC_OFS_COMMS: rd_word = tx_word;
        `DBC_OFS_ISTAT: rd_word = {28'h0, istat};
        `DBC_OFS_IMASK: rd_word = {28'h0, imask};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // next state of bus, registers and debug logic
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_ctrl_req = ctrl_req;
    next_tx_full = tx_full;
    next_tx_word = tx_word;
    next_imask = imask;
    next_wp_addr = wp_addr;
    next_wp_amask = wp_amask;
    next_wp_data = wp_data;
    next_wp_ctrl = wp_ctrl;
    restart = 1'b0;
    // address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    wr_go = aw_held && w_held && !bvalid;
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `DBC_RESP_OKAY;
      if (is_wp(aw_addr) && aw_addr[1:0] == 2'h0) begin
        case (aw_addr[3:2])
          `DBC_WP_ADDR: next_wp_addr[aw_addr[4]] =
            merge(wp_addr[aw_addr[4]], w_data, w_strb);
          `DBC_WP_AMASK: next_wp_amask[aw_addr[4]] =
            merge(wp_amask[aw_addr[4]], w_data, w_strb);
          `DBC_WP_DATA: next_wp_data[aw_addr[4]] =
            merge(wp_data[aw_addr[4]], w_data, w_strb);
          default: if (w_strb[0]) next_wp_ctrl[aw_addr[4]] = w_data[7:0];
        endcase
      end else begin
        case (aw_addr)
          `DBC_OFS_CTRL: if (w_strb[0]) begin
            restart = w_data[`DBC_CTRL_RESTART];
            next_ctrl_req = w_data[`DBC_CTRL_DBGREQ];
          end
          // RL1: loading the word fills the buffer
          `DBC_OFS_COMMS: begin
            next_tx_word = merge(tx_word, w_data, w_strb);
            next_tx_full = 1'b1;
          end
          `DBC_OFS_IMASK: if (w_strb[0]) next_imask = w_data[3:0];
          `DBC_OFS_STATE, `DBC_OFS_ISTAT: next_bresp = `DBC_RESP_OKAY;
          default: next_bresp = `DBC_RESP_SLVERR;
        endcase
      end
    end
    if (bvalid && s_axi_bready) next_bvalid = 1'b0;
    // RL1: drained unless refilled this cycle
    if (tap.comms_read && !(wr_go && aw_addr == `DBC_OFS_COMMS)) begin
      next_tx_full = 1'b0;
    end
    rd_go = s_axi_arvalid && s_axi_arready;
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = rd_ok ? `DBC_RESP_OKAY : `DBC_RESP_SLVERR;
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // debug entry, pipeline tags, events
  always_comb begin
    // RL4: request combine
    next_intreq = external_debug_request || ctrl_req;
    // RL10: tag at fetch, follow into execute, spent once executed
    next_dec_tag = dec_tag;
    next_exe_tag = exe_tag;
    if (core.exec_valid) next_exe_tag = 1'b0;
    if (core.pipe_advance) begin
      next_exe_tag = dec_tag;
      next_dec_tag = 1'b0;
    end
    if (core.fetch_complete) next_dec_tag = instruction_breakpoint_in;
    // RL3: RL5: RL11: entry causes gated by enable
    enter = debug_features_enable && (external_debug_request || ctrl_req
      || (exe_tag && core.exec_valid && !core.exec_discard)
      || (core.data_req_end && data_watchpoint_in) || (|armed_hit));
    next_mode = mode;
    if (!debug_features_enable) begin
      next_mode = dbc_pkg::MODE_RUN;
    end else if (enter) begin
      next_mode = dbc_pkg::MODE_DEBUG;
    end else if (restart) begin
      next_mode = dbc_pkg::MODE_RUN;
    end
    // RL7: only instructions that really execute
    next_iexec = core.exec_valid && core.exec_cond_pass && !core.exec_discard;
    // RL8: unit matches straight out
    next_rng = range_hit;
    // sticky events, set wins over read clear
    next_istat = istat;
    if (rd_go && s_axi_araddr == `DBC_OFS_ISTAT) next_istat = 4'h0;
    next_istat[`DBC_IRQ_ENTRY] = next_istat[`DBC_IRQ_ENTRY]
      || (next_mode == dbc_pkg::MODE_DEBUG && mode == dbc_pkg::MODE_RUN);
    next_istat[`DBC_IRQ_TXEMPTY] = next_istat[`DBC_IRQ_TXEMPTY]
      || (tx_full && !next_tx_full);
    next_istat[`DBC_IRQ_RNG0] = next_istat[`DBC_IRQ_RNG0] || range_hit[0];
    next_istat[`DBC_IRQ_RNG1] = next_istat[`DBC_IRQ_RNG1] || range_hit[1];
    next_irq_q = |(next_istat & next_imask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= `DBC_RST_WORD;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `DBC_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `DBC_RESP_OKAY;
      rdata <= `DBC_RST_WORD;
      mode <= dbc_pkg::MODE_RUN;
      ctrl_req <= 1'b0;
      tx_full <= 1'b0;
      tx_word <= `DBC_RST_WORD;
      dec_tag <= 1'b0;
      exe_tag <= 1'b0;
      istat <= 4'h0;
      imask <= `DBC_RST_IMASK;
      irq_q <= 1'b0;
      iexec <= 1'b0;
      intreq <= 1'b0;
      rng <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        wp_addr[i] <= `DBC_RST_WORD;
        wp_amask[i] <= `DBC_RST_WORD;
        wp_data[i] <= `DBC_RST_WORD;
        wp_ctrl[i] <= `DBC_RST_WPCTRL;
      end
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      mode <= next_mode;
      ctrl_req <= next_ctrl_req;
      tx_full <= next_tx_full;
      tx_word <= next_tx_word;
      dec_tag <= next_dec_tag;
      exe_tag <= next_exe_tag;
      istat <= next_istat;
      imask <= next_imask;
      irq_q <= next_irq_q;
      iexec <= next_iexec;
      intreq <= next_intreq;
      rng <= next_rng;
      wp_addr <= next_wp_addr;
      wp_amask <= next_wp_amask;
      wp_data <= next_wp_data;
      wp_ctrl <= next_wp_ctrl;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  // RL1: empty flag
  assign comms_tx_empty = !tx_full;
  assign comms_tx_data = tx_word;
  // RL2: acknowledge is the mode flop
  assign debug_state_ack = mode == dbc_pkg::MODE_DEBUG;
  assign internal_debug_request = intreq;
  assign instruction_executed = iexec;
  assign watchpoint_range_match = rng;
  assign irq = irq_q;

  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_comms_fill: assert property (wr_go && aw_addr == `DBC_OFS_COMMS
    |=> !comms_tx_empty) // RL1
    else $error("comms word written but empty shown");
  a_ack_cause: assert property ($rose(debug_state_ack)
    |-> $past(enter)) // RL2
    else $error("acknowledge rose without cause");
  a_enable_gate: assert property (!debug_features_enable
    |=> !debug_state_ack) // RL3
    else $error("debug state while disabled");
  a_req_combine: assert property (##1 internal_debug_request
    == $past(external_debug_request || ctrl_req)) // RL4
    else $error("internal request mismatch");
  a_ext_entry: assert property (debug_features_enable
    && external_debug_request |=> debug_state_ack) // RL5
    else $error("external request ignored");
  a_exec_pulse: assert property (core.exec_valid && core.exec_cond_pass
    && !core.exec_discard |=> instruction_executed) // RL7
    else $error("executed pulse missing");
  a_exec_fail: assert property ((!core.exec_cond_pass || core.exec_discard)
    |=> !instruction_executed) // RL7
    else $error("executed pulse for failed instruction");
  a_range_out: assert property (##1 watchpoint_range_match
    == $past(range_hit)) // RL8
    else $error("range output mismatch");
  a_bkpt_entry: assert property (debug_features_enable && exe_tag
    && core.exec_valid && !core.exec_discard |=> debug_state_ack) // RL10
    else $error("tagged instruction did not stop");
  a_wpt_entry: assert property (debug_features_enable
    && core.data_req_end && data_watchpoint_in |=> debug_state_ack) // RL11
    else $error("data watchpoint ignored");
  c_ext_entry: cover property (external_debug_request ##1 debug_state_ack);
  c_bkpt_entry: cover property (exe_tag && core.exec_valid
    ##1 debug_state_ack);
  c_comms_cycle: cover property (!comms_tx_empty ##[1:20] comms_tx_empty);
  c_irq: cover property ($rose(irq));
endmodule // dbc_debug_ctrl

//--- test/dbc_partner.sv
`timescale 1ns/1ps
// external debugger: raises its request and keeps it until acknowledged
module dbc_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic debug_state_ack,
  output logic external_debug_request
);
  // request register, dropped only once the ack is seen
  // hold until ack
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_debug_request <= 1'b0;
    end else if (start) begin
      external_debug_request <= 1'b1;
    end else if (debug_state_ack) begin
      external_debug_request <= 1'b0;
    end
  end
endmodule // dbc_partner

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, start = 1'b0;
  logic [31:0] s_axi_wdata = '0, scan_id_value = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, external_debug_request, comms_tx_empty;
  logic [1:0] s_axi_bresp, s_axi_rresp, watchpoint_range_match;
  logic [31:0] s_axi_rdata, comms_tx_data, rd, v;
  logic debug_features_enable = 1'b0, data_watchpoint_in = 1'b0;
  logic [1:0] external_match_condition = '0, rs;
  logic instruction_breakpoint_in = 1'b0;
  dbc_pkg::dbc_core_t core = '0;
  dbc_pkg::dbc_tap_t tap = '0;
  logic debug_state_ack, internal_debug_request, irq;
  logic instruction_executed, test_data_out, ex;
  int fail_count = 0, n_compared = 0, t, i, k;
  integer seed = 32'h5df6f641;

  dbc_debug_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .debug_features_enable,
    .external_debug_request, .external_match_condition,
    .instruction_breakpoint_in, .data_watchpoint_in, .scan_id_value,
    .core, .tap, .comms_tx_empty, .comms_tx_data, .debug_state_ack,
    .internal_debug_request, .instruction_executed,
    .watchpoint_range_match, .test_data_out, .irq);
  dbc_partner i_dbg (.aclk, .aresetn, .start, .debug_state_ack,
    .external_debug_request);

  // clock, 8 ns period
  initial begin
    forever #4 aclk = ~aclk;
  end

  task check(input string n, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask

  task final_report;
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // expected executed pulse: ran, passed its condition, not discarded
  function automatic logic exp_exec(input logic vld, input logic pass,
                                    input logic disc);
    return vld && pass && !disc;
  endfunction

  // one write: address and data offered together, bready held to bvalid
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] xr);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    check("bresp", {s_axi_bvalid, s_axi_bresp}, {1'b1, xr});
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  // one read, data and response taken at the rvalid edge
  task rdw(input logic [7:0] a);
    rd = 'x;
    rs = 'x;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // watchdog cuts a hang short
  initial begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("empty", comms_tx_empty, 1'b1);
    check("ack", debug_state_ack, 1'b0);
    check("irq", irq, 1'b0);
    wr(8'h10, 32'h1, 2'h0);
    debug_features_enable <= 1'b1;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    for (t = 0; t < 20 && debug_state_ack !== 1'b1; t++) @(posedge aclk);
    check("ack", debug_state_ack, 1'b1);
    check("intreq", internal_debug_request, 1'b1);
    cyc(3);
    check("ack", debug_state_ack, 1'b1);
    check("intreq", internal_debug_request, 1'b0);
    check("irq", irq, 1'b1);
    rdw(8'h0c);
    check("istat", rd, 32'h1);
    cyc(2);
    check("irq", irq, 1'b0);
    wr(8'h00, 32'h1, 2'h0);
    cyc(2);
    check("ack", debug_state_ack, 1'b0);
    debug_features_enable <= 1'b0;
    wr(8'h00, 32'h2, 2'h0);
    cyc(2);
    check("intreq", internal_debug_request, 1'b1);
    check("ack", debug_state_ack, 1'b0);
    debug_features_enable <= 1'b1;
    cyc(2);
    check("ack", debug_state_ack, 1'b1);
    // drop the request bit first: a standing cause beats restart
    wr(8'h00, 32'h0, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    cyc(2);
    check("ack", debug_state_ack, 1'b0);
    rdw(8'h1c);
    check("unmapped", {rs, rd}, {2'h2, 32'h0});
    wr(8'h1c, 32'h5, 2'h2);
    v = $random(seed);
    wr(8'h08, v, 2'h0);
    check("empty", comms_tx_empty, 1'b0);
    check("txdata", comms_tx_data, v);
    tap.comms_read <= 1'b1;
    @(posedge aclk);
    tap.comms_read <= 1'b0;
    @(posedge aclk);
    check("empty", comms_tx_empty, 1'b1);
    ex = 1'b0;
    repeat (40) begin
      @(posedge aclk);
      check("exec", instruction_executed, ex);
      ex = exp_exec(core.exec_valid, core.exec_cond_pass, core.exec_discard);
      v = $random(seed);
      core.exec_valid <= v[0];
      core.exec_cond_pass <= v[1];
      core.exec_discard <= v[2];
    end
    core <= '0;
    @(posedge aclk);
    for (k = 1; k >= 0; k--) begin
      instruction_breakpoint_in <= 1'b1;
      core.fetch_complete <= 1'b1;
      @(posedge aclk);
      instruction_breakpoint_in <= 1'b0;
      core.fetch_complete <= 1'b0;
      core.pipe_advance <= 1'b1;
      @(posedge aclk);
      core.pipe_advance <= 1'b0;
      core.exec_valid <= 1'b1;
      core.exec_cond_pass <= 1'b1;
      core.exec_discard <= k[0];
      @(posedge aclk);
      core <= '0;
      @(posedge aclk);
      check("bkpt", debug_state_ack, !k[0]);
    end
    wr(8'h00, 32'h1, 2'h0);
    // watchpoint input only at request end
    for (k = 0; k < 2; k++) begin
      data_watchpoint_in <= 1'b1;
      core.data_req_end <= k[0];
      @(posedge aclk);
      data_watchpoint_in <= 1'b0;
      core.data_req_end <= 1'b0;
      @(posedge aclk);
      check("dwpt", debug_state_ack, k[0]);
    end
    wr(8'h00, 32'h1, 2'h0);
    v = $random(seed) | 32'h1;
    wr(8'h20, v, 2'h0);
    wr(8'h2c, 32'hb0, 2'h0);
    for (k = 0; k < 4; k++) begin
      external_match_condition <= k[1:0];
      core.addr <= v;
      core.data_req_end <= 1'b1;
      @(posedge aclk);
      core.data_req_end <= 1'b0;
      @(posedge aclk);
      check("range", watchpoint_range_match, {1'b0, k == 2});
      check("ack", debug_state_ack, 1'b0);
    end
    // enabled unit with matching condition stops the core
    wr(8'h2c, 32'hb1, 2'h0);
    external_match_condition <= 2'h2;
    core.data_req_end <= 1'b1;
    @(posedge aclk);
    core.data_req_end <= 1'b0;
    @(posedge aclk);
    check("armed", debug_state_ack, 1'b1);
    // id code shifted out lsb first
    scan_id_value <= $random(seed);
    tap.ir <= 4'he;
    tap.capture_dr <= 1'b1;
    @(posedge aclk);
    tap.capture_dr <= 1'b0;
    tap.shift_dr <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 32; i++) begin
      @(posedge aclk);
      check("tdo", test_data_out, scan_id_value[i]);
      // exactly 32 shifts, no stray extra one
      if (i == 30) tap.shift_dr <= 1'b0;
    end
    final_report();
  end
endmodule // testbench
